/* crc8_byte.v */
// Purpose: one byte step of a CRC8 over the offset data area
// Assumes: combinational, caller registers the result
// Notes:   polynomial from the shared header
`timescale 1ns/100ps
`include "preset_regs.vh"
module crc8_byte (
   input  wire [7:0] crc_in,
   input  wire [7:0] data_in,
   output reg  [7:0] crc_out
);
   integer i;
   reg [7:0] c;
   always @* begin
      c = crc_in ^ data_in;
      for (i = 0; i < 8; i = i + 1) begin
         if (c[7])
            c = {c[6:0], 1'b0} ^ `CRC8_POLY;
         else
            c = {c[6:0], 1'b0};
      end
      crc_out = c;
   end
endmodule

/* edge_detect.v */
// Purpose: two-stage synchroniser with falling edge pulse
// Assumes: single clock sys_clk, synchronous active low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module edge_detect (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire enable,
   input  wire pin_in,
   output reg  fall_pulse
);
   reg meta_q;
   reg sync_q;
   reg last_q;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q     <= 1'b1;
         sync_q     <= 1'b1;
         last_q     <= 1'b1;
         fall_pulse <= 1'b0;
      end else begin
         meta_q     <= pin_in;
         sync_q     <= meta_q;
         last_q     <= sync_q;
         fall_pulse <= enable & last_q & ~sync_q;
      end
   end
endmodule

/* ee_model.sv */
// Purpose: EEPROM side model taking the offset byte stream
// Assumes: one byte per ee_wr request, ready sampled on sys_clk
// Notes:   slow adds wait cycles before each ready pulse
`timescale 1ns/100ps
module ee_model (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       slow,
   input  wire       ee_wr,
   input  wire [7:0] ee_addr,
   input  wire [7:0] ee_data,
   output reg        ee_ready
);
   // ===========================================================
   // Byte acceptor
   reg     [7:0] mem [0:255];
   reg     [1:0] wait_q;
   integer       wr_count;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ee_ready <= 1'b0;
         wait_q   <= 2'h0;
         wr_count <= 0;
      end else if (ee_ready) begin
         // Ready lasts one cycle so each request is taken once
         ee_ready <= 1'b0;
         if (ee_wr) begin
            mem[ee_addr] <= ee_data;
            wr_count     <= wr_count + 1;
         end
      end else if (ee_wr) begin
         ee_ready <= !slow || wait_q == 2'h3;
         wait_q   <= wait_q + 2'h1;
      end
   end
endmodule

/* position_offset_preset_control.v */
// Purpose: offset, effective offset and preset sequence of the encoder
// Assumes: byte register port, position and nonius/multiturn inputs
//          synchronous to sys_clk
// Notes:   EEPROM writes are a byte stream with strobe and ready
`timescale 1ns/100ps
`include "preset_regs.vh"

// Functional notes
// - Preset pin on port A first pin only when function select is 2..7.
// - Each falling edge of the preset pin runs the selected edge command while idle, unless a command write comes in the same cycle.
// - Edge codes 00 and FF do nothing; 01..10 match command codes.
// - After restart or redefine, effective offset = stored + nonius, plus turns only with extern_multiturn.
// - Effective offset is subtracted from each synchronized position.
// - Preset starts by command or by pin edge selecting a preset code.
// - Preset first halts quadrature converter, then captures position.
// - Preset computes new effective offset from position and setpoint.
// - Preset recomputes stored offset; EEPROM write only for store variant.
// - Preset finally restarts the quadrature converter.
// - Stored offset is 36 bits, nibble in bits 7:4 plus four bytes.
// - Setpoint is 36 bits, nibble in bits 7:4 plus four bytes.
// - Effective offset bits 35:12 read back at 20h..22h.
// - Data level flag holds data pin level before clock pin change.
// - Command 08 presets offset only; 09 presets and saves to EEPROM.
// - After either preset the CRC8 of the offset area is updated.
module position_offset_preset_control (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire [2:0]  port_a_function_select,
   input  wire        port_a_first_pin,
   input  wire        startup_done,
   input  wire        extern_multiturn,
   input  wire [35:0] nonius_turn_offset,
   input  wire [35:0] sync_position,
   input  wire        sync_valid,
   output reg  [35:0] out_position,
   output reg         out_valid,
   output reg         quad_run,
   input  wire        multiturn_data_pin,
   output reg         multiturn_clock_pin,
   output reg         ee_wr,
   output reg  [7:0]  ee_addr,
   output reg  [7:0]  ee_data,
   input  wire        ee_ready,
   output reg  [7:0]  offset_crc8,
   output reg  [7:0]  other_cmd,
   output reg         other_cmd_go,
   output reg         busy
);
   localparam [6:0] ST_IDLE  = 7'h01;
   localparam [6:0] ST_HALT  = 7'h02;
   localparam [6:0] ST_CAPT  = 7'h04;
   localparam [6:0] ST_CALC  = 7'h08;
   localparam [6:0] ST_STORE = 7'h10;
   localparam [6:0] ST_CRC   = 7'h20;
   localparam [6:0] ST_RUN   = 7'h40;

   reg [6:0]  state_q;
   reg [35:0] stored_offset_q;
   reg [35:0] preset_setpoint_q;
   reg [35:0] eff_offset_q;
   reg [35:0] cap_pos_q;
   reg [7:0]  edge_command_select_q;
   reg        store_q;
   reg        mt_flag_q;
   reg [2:0]  byte_idx_q;
   reg [7:0]  crc_q;
   reg        start_up_q;
   reg        redefine_q;
   wire       pin_fall;
   wire [7:0] crc_next;
   reg  [7:0] cur_byte;
   reg  [7:0] cmd_code;
   reg        cmd_go;
   reg        pin_enable;
   reg [35:0] amend_term;
   reg [35:0] new_eff;

   // ========================================================
   // Preset pin and command decode
   // ========================================================
   always @* begin
      pin_enable = (port_a_function_select >= `FSEL_PIN_LO) &&
                   (port_a_function_select <= `FSEL_PIN_HI);
   end

   // The detector keeps sampling while disabled, so enabling the pin
   // while it is held low gives no false edge
   // synchronised falling edge
   edge_detect u_edge (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .enable     (pin_enable),
      .pin_in     (port_a_first_pin),
      .fall_pulse (pin_fall)
   );

   // Command register is write-only and reads back as zero
   wire cmd_write = reg_wr && (reg_addr == `ADDR_COMMAND);

   always @* begin
      cmd_code = `CMD_NONE;
      cmd_go   = 1'b0;
      // Register write wins if both arrive together; the edge is retried
      // never, so software should not race the pin.
      if (cmd_write) begin
         cmd_code = reg_wdata;
         cmd_go   = (reg_wdata != `CMD_NONE) && (reg_wdata <= `CMD_LAST);
      end else if (pin_fall) begin
         cmd_code = edge_command_select_q;
         cmd_go   = (edge_command_select_q != `CMD_NONE) &&
                    (edge_command_select_q != `CMD_ALL_NONE) &&
                    (edge_command_select_q <= `CMD_LAST);
      end
   end

   wire is_preset = cmd_go && ((cmd_code == `CMD_PRESET) ||
                               (cmd_code == `CMD_PRESET_STORE));

   // Offset image byte order, nibble byte first
   always @* begin
      case (byte_idx_q)
         3'h0:    cur_byte = {stored_offset_q[3:0], 4'h0};
         3'h1:    cur_byte = stored_offset_q[11:4];
         3'h2:    cur_byte = stored_offset_q[19:12];
         3'h3:    cur_byte = stored_offset_q[27:20];
         default: cur_byte = stored_offset_q[35:28];
      endcase
   end

   crc8_byte u_crc (
      .crc_in  (crc_q),
      .data_in (cur_byte),
      .crc_out (crc_next)
   );

   // ========================================================
   // Offset arithmetic
   // ========================================================
   // Without an external multiturn only the nonius bits are added,
   // so a stale turn count cannot leak into the singleturn offset
   always @* begin
      if (extern_multiturn)
         amend_term = nonius_turn_offset;
      else
         amend_term = {24'h0, nonius_turn_offset[11:0]};
   end

   // offset that puts the captured position on the setpoint
   // The difference wraps at 36 bits like the output subtraction
   always @* begin
      new_eff = cap_pos_q - preset_setpoint_q;
   end

   // ========================================================
   // Registers and preset sequence
   // ========================================================
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q               <= ST_IDLE;
         stored_offset_q       <= 36'h0;
         preset_setpoint_q     <= 36'h0;
         eff_offset_q          <= 36'h0;
         cap_pos_q             <= 36'h0;
         edge_command_select_q <= `CMD_NONE;
         store_q               <= 1'b0;
         mt_flag_q             <= 1'b0;
         byte_idx_q            <= 3'h0;
         crc_q                 <= `CRC8_INIT;
         start_up_q            <= 1'b0;
         redefine_q            <= 1'b0;
         reg_rdata             <= 8'h00;
         out_position          <= 36'h0;
         out_valid             <= 1'b0;
         // Converter runs from reset; only a preset stops it
         quad_run              <= 1'b1;
         multiturn_clock_pin   <= 1'b0;
         ee_wr                 <= 1'b0;
         ee_addr               <= 8'h00;
         ee_data               <= 8'h00;
         offset_crc8           <= `CRC8_INIT;
         other_cmd             <= `CMD_NONE;
         other_cmd_go          <= 1'b0;
         busy                  <= 1'b0;
      end else begin
         other_cmd_go <= 1'b0;
         start_up_q   <= startup_done;
         redefine_q   <= 1'b0;
         out_valid <= sync_valid;
         // Samples keep flowing in a preset, with the old offset until ST_CALC loads the new one
         if (sync_valid)
            out_position <= sync_position - eff_offset_q;

         // Data registers are frozen during a preset so the setpoint
         // and stored offset cannot change under the running sequence
         if (reg_wr && state_q == ST_IDLE) begin
            case (reg_addr)
               `ADDR_OFF_NIB:  stored_offset_q[3:0]   <= reg_wdata[7:4];
               `ADDR_OFF_B1:   stored_offset_q[11:4]  <= reg_wdata;
               `ADDR_OFF_B2:   stored_offset_q[19:12] <= reg_wdata;
               `ADDR_OFF_B3:   stored_offset_q[27:20] <= reg_wdata;
               `ADDR_OFF_B4:   stored_offset_q[35:28] <= reg_wdata;
               `ADDR_SET_NIB:  preset_setpoint_q[3:0]   <= reg_wdata[7:4];
               `ADDR_SET_B1:   preset_setpoint_q[11:4]  <= reg_wdata;
               `ADDR_SET_B2:   preset_setpoint_q[19:12] <= reg_wdata;
               `ADDR_SET_B3:   preset_setpoint_q[27:20] <= reg_wdata;
               `ADDR_SET_B4:   preset_setpoint_q[35:28] <= reg_wdata;
               `ADDR_EDGE_SEL: edge_command_select_q    <= reg_wdata;
               default: ;
            endcase
         end

         // Read data stands until the next read strobe
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_OFF_NIB:  reg_rdata <= {stored_offset_q[3:0], 4'h0};
               `ADDR_OFF_B1:   reg_rdata <= stored_offset_q[11:4];
               `ADDR_EFF_B2:   reg_rdata <= eff_offset_q[19:12];
               `ADDR_EFF_B3:   reg_rdata <= eff_offset_q[27:20];
               `ADDR_EFF_B4:   reg_rdata <= eff_offset_q[35:28];
               `ADDR_EDGE_SEL: reg_rdata <= edge_command_select_q;
               `ADDR_OFF_B2:   reg_rdata <= stored_offset_q[19:12];
               `ADDR_OFF_B3:   reg_rdata <= stored_offset_q[27:20];
               `ADDR_OFF_B4:   reg_rdata <= stored_offset_q[35:28];
               `ADDR_SET_NIB:  reg_rdata <= {preset_setpoint_q[3:0], 4'h0};
               `ADDR_SET_B1:   reg_rdata <= preset_setpoint_q[11:4];
               `ADDR_SET_B2:   reg_rdata <= preset_setpoint_q[19:12];
               `ADDR_SET_B3:   reg_rdata <= preset_setpoint_q[27:20];
               `ADDR_SET_B4:   reg_rdata <= preset_setpoint_q[35:28];
               `ADDR_MT_FLAG:  reg_rdata <= {7'h00, mt_flag_q};
               default:        reg_rdata <= 8'h00;
            endcase
         end

         // Commands other than preset run only while idle
         // Drive commands sample the data pin on the edge of the change
         if (cmd_go && !is_preset && state_q == ST_IDLE) begin
            case (cmd_code)
               `CMD_DRIVE_HIGH: begin
                  mt_flag_q           <= multiturn_data_pin;
                  multiturn_clock_pin <= 1'b1;
               end
               `CMD_DRIVE_LOW: begin
                  mt_flag_q           <= multiturn_data_pin;
                  multiturn_clock_pin <= 1'b0;
               end
               `CMD_ABS_REDEF, `CMD_SOFT_RESTART: redefine_q <= 1'b1;
               default: ;
            endcase
            other_cmd    <= cmd_code;
            other_cmd_go <= 1'b1;
         end

         // amend offset after startup or redefinition
         if ((startup_done && !start_up_q) || redefine_q)
            eff_offset_q <= stored_offset_q + amend_term;

         // ========================================================
         // Preset sequence
         // ========================================================
         case (state_q)
            ST_IDLE: begin
               busy <= 1'b0;
               // A preset asked for outside ST_IDLE is dropped, not queued
               if (is_preset) begin
                  store_q <= (cmd_code == `CMD_PRESET_STORE);
                  busy    <= 1'b1;
                  state_q <= ST_HALT;
               end
            end
            ST_HALT: begin
               quad_run <= 1'b0;
               state_q  <= ST_CAPT;
            end
            ST_CAPT: begin
               // Stalls until a sample comes; no sample, no preset
               if (sync_valid) begin
                  cap_pos_q <= sync_position;
                  state_q   <= ST_CALC;
               end
            end
            ST_CALC: begin
               eff_offset_q    <= new_eff;
               // stored offset moves by the same amount
               stored_offset_q <= stored_offset_q + new_eff - eff_offset_q;
               byte_idx_q      <= 3'h0;
               crc_q           <= `CRC8_INIT;
               state_q         <= store_q ? ST_STORE : ST_CRC;
            end
            ST_STORE: begin
               // ee_wr drops for a cycle between bytes so each is taken once
               // EEPROM write for store variant
               if (ee_wr && ee_ready) begin
                  ee_wr <= 1'b0;
                  if (byte_idx_q == `EE_OFF_BYTES - 3'h1) begin
                     byte_idx_q <= 3'h0;
                     state_q    <= ST_CRC;
                  end else begin
                     byte_idx_q <= byte_idx_q + 3'h1;
                  end
               end else if (!ee_wr) begin
                  ee_wr   <= 1'b1;
                  ee_addr <= `EE_OFF_BASE + {5'h00, byte_idx_q};
                  ee_data <= cur_byte;
               end
            end
            ST_CRC: begin
               // One byte a cycle; the sum is published only when complete
               // CRC8 over offset bytes
               crc_q <= crc_next;
               if (byte_idx_q == `EE_OFF_BYTES - 3'h1) begin
                  offset_crc8 <= crc_next;
                  state_q     <= ST_RUN;
               end else begin
                  byte_idx_q <= byte_idx_q + 3'h1;
               end
            end
            ST_RUN: begin
               // Restart comes one cycle before busy falls
               // restart converter last
               quad_run <= 1'b1;
               state_q  <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

/* preset_chk.sv */
// Purpose: port checker for the offset and preset block
// Assumes: one clock sys_clk, rst_n synchronous active low
// Notes:   bound to the offset and preset module by the bind below the checker
`timescale 1ns/100ps
module preset_chk (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        sync_valid,
   input wire        out_valid,
   input wire        quad_run,
   input wire        ee_wr,
   input wire [7:0]  ee_addr,
   input wire [7:0]  ee_data,
   input wire        ee_ready,
   input wire [7:0]  other_cmd,
   input wire        other_cmd_go,
   input wire        busy
);
   // ===========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_halt;
      busy ##1 !quad_run;
   endsequence
   sequence s_hold;
      ee_wr && $stable(ee_addr) && $stable(ee_data);
   endsequence
   a_halt_first: assert property ($rose(busy) |-> s_halt)
      else $error("converter not halted at preset start");
   a_quad_gated: assert property (!quad_run |-> busy)
      else $error("converter stopped outside a preset");
   a_quad_back: assert property ($fell(busy) |-> quad_run)
      else $error("converter not restarted at preset end");
   a_out_follow: assert property (
      sync_valid && !busy |-> ##[1:2] out_valid)
      else $error("position sample produced no output");
   a_ee_hold: assert property (ee_wr && !ee_ready |=> s_hold)
      else $error("store request changed before ready");
   a_ee_in_preset: assert property (ee_wr |-> busy)
      else $error("store request outside a preset");
   a_ee_window: assert property (
      ee_wr |-> ee_addr >= 8'h23 && ee_addr <= 8'h27)
      else $error("store address outside offset image");
   a_go_code: assert property (other_cmd_go |->
      other_cmd >= 8'h01 && other_cmd <= 8'h10 &&
      other_cmd != 8'h08 && other_cmd != 8'h09)
      else $error("launched command code out of range");
   a_go_single: assert property (other_cmd_go |=> !other_cmd_go)
      else $error("command launched twice");
endmodule
bind position_offset_preset_control preset_chk u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .sync_valid(sync_valid),
   .out_valid(out_valid), .quad_run(quad_run), .ee_wr(ee_wr),
   .ee_addr(ee_addr), .ee_data(ee_data), .ee_ready(ee_ready),
   .other_cmd(other_cmd), .other_cmd_go(other_cmd_go), .busy(busy));

/* preset_regs.vh */
// Purpose: constants for the position offset and preset block
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   included by the CRC step, the offset and preset block and the bench
`ifndef PRESET_REGS_VH
`define PRESET_REGS_VH
`define ADDR_OFF_NIB     8'h1E
`define ADDR_OFF_B1      8'h1F
`define ADDR_EFF_B2      8'h20
`define ADDR_EFF_B3      8'h21
`define ADDR_EFF_B4      8'h22
`define ADDR_EDGE_SEL    8'h25
`define ADDR_OFF_B2      8'h48
`define ADDR_OFF_B3      8'h49
`define ADDR_OFF_B4      8'h4A
`define ADDR_SET_NIB     8'h4D
`define ADDR_SET_B1      8'h4E
`define ADDR_SET_B2      8'h4F
`define ADDR_SET_B3      8'h50
`define ADDR_SET_B4      8'h51
`define ADDR_MT_FLAG     8'h60
`define ADDR_COMMAND     8'h75
`define EE_OFF_BASE      8'h23
`define EE_SET_BASE      8'h2A
`define CMD_NONE         8'h00
`define CMD_LAST         8'h10
`define CMD_ALL_NONE     8'hFF
`define CMD_ABS_REDEF    8'h03
`define CMD_SOFT_RESTART 8'h07
`define CMD_PRESET       8'h08
`define CMD_PRESET_STORE 8'h09
`define CMD_DRIVE_HIGH   8'h0F
`define CMD_DRIVE_LOW    8'h10
`define FSEL_PIN_LO      3'h2
`define FSEL_PIN_HI      3'h7
`define NIB_LSB          4
`define CRC8_POLY        8'h07
`define CRC8_INIT        8'hFF
`define EE_OFF_BYTES     3'h5
`endif

/* tb_top.sv */
// Purpose: self-checking bench for the offset and preset block
// Assumes: 25 MHz sys_clk, inputs driven 1 ns after each rising edge
// Notes:   random values from an xorshift seeded with 2759
`timescale 1ns/100ps
`include "preset_regs.vh"
`define CHK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
   bad_count = bad_count + 1; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   reg         sys_clk, rst_n, reg_wr, reg_rd, pin, startup_done;
   reg         ext_mt, sync_valid, mt_data, slow;
   reg  [2:0]  fsel;
   reg  [7:0]  reg_addr, reg_wdata, d, code;
   reg  [31:0] seed, r;
   reg  [35:0] nto, sync_pos, stored, setp, eff, p;
   wire [7:0]  reg_rdata, ee_addr, ee_data, crc, ocmd;
   wire [35:0] out_pos;
   wire        out_valid, quad_run, mt_clk, ee_wr, ee_ready, go, busy;
   integer     bad_count, tests_run, cyc, i, gc;
   position_offset_preset_control u_position_offset_preset_control (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .port_a_function_select(fsel),
      .port_a_first_pin(pin), .startup_done(startup_done),
      .extern_multiturn(ext_mt), .nonius_turn_offset(nto),
      .sync_position(sync_pos), .sync_valid(sync_valid),
      .out_position(out_pos), .out_valid(out_valid), .quad_run(quad_run),
      .multiturn_data_pin(mt_data), .multiturn_clock_pin(mt_clk),
      .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_data(ee_data),
      .ee_ready(ee_ready), .offset_crc8(crc), .other_cmd(ocmd),
      .other_cmd_go(go), .busy(busy));
   ee_model u_ee_model (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
      .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_data(ee_data),
      .ee_ready(ee_ready));
   // ===========================================================
   // Helpers
   function [31:0] rnd(input dummy);
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   function [35:0] r36(input dummy);
      reg [63:0] t;
      begin
         t = {rnd(0), rnd(0)};
         r36 = t[35:0];
      end
   endfunction
   function [35:0] amend(input [35:0] s);
      amend = s + (ext_mt ? nto : {24'h0, nto[11:0]});
   endfunction
   function [7:0] crc_step(input [7:0] c, input [7:0] b);
      integer k;
      begin
         crc_step = c ^ b;
         for (k = 0; k < 8; k = k + 1)
            crc_step = {crc_step[6:0], 1'b0} ^ (crc_step[7] ? 8'h07 : 8'h00);
      end
   endfunction
   task step;
      begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [7:0] v);
      begin
         reg_addr = a;
         reg_wdata = v;
         reg_wr = 1;
         step;
         reg_wr = 0;
         step;
      end
   endtask
   task rd(input [7:0] a, output [7:0] v);
      begin
         reg_addr = a;
         reg_rd = 1;
         step;
         reg_rd = 0;
         step;
         v = reg_rdata;
      end
   endtask
   function [7:0] a36(input sel, input integer k);
      a36 = sel ? 8'h4D + k : (k < 2 ? 8'h1E + k : 8'h46 + k);
   endfunction
   task wr36(input sel, input [35:0] v);
      integer k;
      for (k = 0; k < 5; k = k + 1)
         wr(a36(sel, k), k == 0 ? {v[3:0], 4'h0} : v[k*8-4 +: 8]);
   endtask
   task chk36(input sel, input [35:0] v);
      integer k;
      for (k = 0; k < 5; k = k + 1) begin
         rd(a36(sel, k), d);
         if (k == 0)
            `CHK(d[7:4], v[3:0])
         else
            `CHK(d, v[k*8-4 +: 8])
      end
   endtask
   task chk_eff;
      integer k;
      for (k = 0; k < 3; k = k + 1) begin
         rd(8'h20 + k, d);
         `CHK(d, eff[12+8*k +: 8])
      end
   endtask
   task pos(input [35:0] q, input chk);
      integer n;
      begin
         sync_pos = q;
         sync_valid = 1;
         step;
         sync_valid = 0;
         n = 0;
         while (chk && out_valid !== 1'b1 && n < 4) begin
            step;
            n = n + 1;
         end
         if (chk) begin
            `CHK(out_valid, 1'b1)
            `CHK(out_pos, q - eff)
         end
      end
   endtask
   task preset(input via_pin, input [7:0] c);
      integer k, n0;
      reg [7:0] c8;
      begin
         n0 = u_ee_model.wr_count;
         p = r36(0);
         r = rnd(0);
         fsel = 3'h2 + {1'b0, r[1:0]};
         slow = r[2];
         // started by pin edge or command
         if (via_pin) begin
            wr(`ADDR_EDGE_SEL, c);
            pin = 0;
         end else
            wr(`ADDR_COMMAND, c);
         while (quad_run !== 1'b0)
            step;
         pos(p, 0);
         while (busy !== 1'b0)
            step;
         pin = 1;
         // New stored offset excludes the nonius and turn share
         eff = p - setp;
         stored = eff - amend(36'h0);
         chk_eff;
         pos(r36(0), 1);
         chk36(0, stored);
         `CHK(u_ee_model.wr_count - n0, c == `CMD_PRESET ? 0 : 5)
         if (c == `CMD_PRESET_STORE) begin
            `CHK(u_ee_model.mem[8'h23][7:4], stored[3:0])
            for (k = 1; k < 5; k = k + 1)
               `CHK(u_ee_model.mem[8'h23+k], stored[k*8-4 +: 8])
         end
         c8 = crc_step(`CRC8_INIT, {stored[3:0], 4'h0});
         for (k = 1; k < 5; k = k + 1)
            c8 = crc_step(c8, stored[k*8-4 +: 8]);
         `CHK(crc, c8)
         $display("test preset %h done", c);
      end
   endtask
   task conclude;
      begin
         $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // ===========================================================
   // Clock, watchdog and main sequence
   initial begin
      sys_clk = 0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         conclude;
      end
   end
   initial begin
      {reg_wr, reg_rd, startup_done, ext_mt, sync_valid, mt_data} = 0;
      {reg_addr, reg_wdata, sync_pos, nto, slow} = 0;
      {bad_count, tests_run, cyc} = 0;
      pin = 1;
      fsel = 3'h3;
      rst_n = 0;
      seed = 2759;
      repeat (20) @(posedge sys_clk);
      #1;
      rst_n = 1;
      `CHK(quad_run, 1'b1)
      `CHK(crc, `CRC8_INIT)
      rd(8'h30, d);
      `CHK(d, 8'h00)
      stored = r36(0);
      setp = r36(0);
      nto = r36(0);
      r = rnd(0);
      ext_mt = r[0];
      wr36(0, stored);
      wr36(1, setp);
      chk36(0, stored);
      chk36(1, setp);
      startup_done = 1;
      repeat (4) step;
      eff = amend(stored);
      chk_eff;
      wr(`ADDR_EFF_B2, ~eff[19:12]);
      chk_eff;
      nto = r36(0);
      ext_mt = ~ext_mt;
      wr(`ADDR_COMMAND, `CMD_ABS_REDEF);
      repeat (4) step;
      eff = amend(stored);
      chk_eff;
      for (i = 0; i < 20; i = i + 1)
         pos(r36(0), 1);
      $display("test offset done");
      for (i = 0; i < 4; i = i + 1)
         preset(i[0], i[1] ? `CMD_PRESET : `CMD_PRESET_STORE);
      // Pin edge must be ignored outside function codes 2..7
      r = rnd(0);
      fsel = {2'h0, r[0]};
      wr(`ADDR_EDGE_SEL, `CMD_PRESET);
      pin = 0;
      repeat (8) step;
      `CHK(busy, 1'b0)
      pin = 1;
      fsel = 3'h7;
      step;
      for (i = 0; i < 18; i = i + 1) begin
         code = (i == 17) ? 8'hFF : i[7:0];
         if (code != 8 && code != 9) begin
            r = rnd(0);
            mt_data = r[0];
            if (code == `CMD_ABS_REDEF || code == `CMD_SOFT_RESTART) begin
               nto = r36(0);
               eff = amend(stored);
            end
            wr(`ADDR_EDGE_SEL, code);
            pin = 0;
            gc = 0;
            repeat (8) begin
               step;
               if (go === 1'b1) begin
                  gc = gc + 1;
                  d = ocmd;
               end
            end
            pin = 1;
            step;
            `CHK(gc, (code != 0 && code != 8'hFF) ? 1 : 0)
            if (gc == 1)
               `CHK(d, code)
            if (code == `CMD_DRIVE_HIGH || code == `CMD_DRIVE_LOW) begin
               `CHK(mt_clk, code == `CMD_DRIVE_HIGH)
               rd(`ADDR_MT_FLAG, d);
               `CHK(d[0], mt_data)
            end
            if (code == `CMD_ABS_REDEF || code == `CMD_SOFT_RESTART)
               chk_eff;
         end
      end
      $display("test edge codes done");
      conclude;
   end
endmodule
